// ---- haptic_mode_trigger_control_test.sv ----
`timescale 1ns/100ps
module haptic_mode_trigger_control_test;
   logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [3:0]  wstrb;
   logic        seq_done, test_done, test_fail, play_start, play_cancel;
   logic        standby, drive_active, drive_from_pin, pin_is_analog;
   logic        ac_coupling_enable, realtime_value_sign_format, test_run;
   logic [7:0]  realtime_drive_value;
   hmt_pkg::hmt_mode_t mode;
   int          n_errors, num_checks, n_start, n_cancel, cyc;
   hmt_link_if link ();
   hmt_device u_hmt_device (.clk(clk), .rst(rst), .link(link),
      .seq_done(seq_done), .test_done(test_done), .test_fail(test_fail),
      .play_start(play_start), .play_cancel(play_cancel),
      .standby(standby), .mode(mode), .drive_active(drive_active),
      .drive_from_pin(drive_from_pin), .pin_is_analog(pin_is_analog),
      .ac_coupling_enable(ac_coupling_enable),
      .realtime_drive_value(realtime_drive_value),
      .realtime_value_sign_format(realtime_value_sign_format),
      .test_run(test_run));
   hmt_host u_hmt_host (.clk(clk), .rst(rst), .link(link),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .irq(irq));
   hmt_link_checker u_hmt_link_checker (.clk(clk), .rst(rst),
      .req(link.req), .we(link.we), .addr(link.addr), .wdata(link.wdata),
      .rdata(link.rdata), .ack(link.ack), .trig(link.trig));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Pulses are one cycle; sample between edges
   always @(negedge clk) begin
      if (play_start === 1'b1) n_start++;
      if (play_cancel === 1'b1) n_cancel++;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         end_sim();
      end
   end
   task automatic end_sim;
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_d, w_d, aw_t, w_t;
      aw_d = 1'b0;
      w_d = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_d && w_d)) begin
         @(negedge clk);
         aw_t = !aw_d && awready === 1'b1;
         w_t = !w_d && wready === 1'b1;
         @(posedge clk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
         aw_d = aw_d || aw_t;
         w_d = w_d || w_t;
      end
      do begin
         @(negedge clk);
         aw_t = bvalid === 1'b1;
         @(posedge clk);
      end while (!aw_t);
      bready <= 1'b0;
      // An edge passes so a following call never re-drives in this step
      @(posedge clk);
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      logic got;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge clk);
         got = arready === 1'b1;
         @(posedge clk);
      end while (!got);
      arvalid <= 1'b0;
      do begin
         @(negedge clk);
         got = rvalid === 1'b1;
         d = rdata;
         r = rresp;
         @(posedge clk);
      end while (!got);
      rready <= 1'b0;
      @(posedge clk);
   endtask : axi_rd
   // Launch one link transfer and poll until the host is idle
   task automatic dev_xfer(input logic w, input logic [7:0] a, d,
                           output logic [7:0] q);
      logic [31:0] v;
      logic [1:0]  r;
      axi_wr(8'h00, {15'h0, w, a, d});
      do axi_rd(8'h04, v, r); while (v[8] !== 1'b0);
      q = v[7:0];
   endtask : dev_xfer
   task automatic wr(input logic [7:0] a, d);
      logic [7:0] q;
      dev_xfer(1'b1, a, d, q);
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, e);
      logic [7:0] q;
      dev_xfer(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask : rd_chk
   task automatic trg(input logic v);
      axi_wr(8'h08, {31'h0, v});
   endtask : trg
   task automatic t_reset;
      rd_chk(8'h01, 8'h40);
      rd_chk(8'h02, 8'h00);
      chk(standby, 1'b1);
   endtask : t_reset
   task automatic t_realtime;
      wr(8'h01, 8'h05);
      chk(drive_active, 1'b1);
      chk(mode, hmt_pkg::HMT_REALTIME);
      wr(8'h02, 8'h80);
      chk(realtime_drive_value, 8'h80);
      wr(8'h02, 8'h7F);
      chk(realtime_drive_value, 8'h7F);
      chk(realtime_value_sign_format, 1'b0);
      wr(8'h1D, 8'h0B);
      chk(realtime_value_sign_format, 1'b1);
      wr(8'h01, 8'h00);
      chk(realtime_drive_value, 8'h00);
      chk(drive_active, 1'b0);
   endtask : t_realtime
   task automatic t_modes;
      for (logic [7:0] m = 8'h03; m < 8'h05; m++) begin
         wr(8'h01, m);
         chk(drive_from_pin, 1'b1);
         chk(drive_active, 1'b1);
      end
      chk(pin_is_analog, 1'b1);
      chk(ac_coupling_enable, 1'b1);
   endtask : t_modes
   task automatic t_int;
      int s;
      wr(8'h01, 8'h00);
      s = n_start;
      trg(1'b1);
      trg(1'b0);
      rd_chk(8'h0C, 8'h00);
      wr(8'h0C, 8'h01);
      chk(n_start, s + 1);
      rd_chk(8'h0C, 8'h01);
      seq_done <= 1'b1;
      @(posedge clk);
      seq_done <= 1'b0;
      rd_chk(8'h0C, 8'h00);
   endtask : t_int
   task automatic t_edge;
      int s, c;
      wr(8'h01, 8'h01);
      s = n_start;
      c = n_cancel;
      trg(1'b1);
      rd_chk(8'h0C, 8'h01);
      chk(n_start, s + 1);
      trg(1'b0);
      trg(1'b1);
      rd_chk(8'h0C, 8'h00);
      chk(n_cancel, c + 1);
      trg(1'b0);
   endtask : t_edge
   task automatic t_level;
      int s, c;
      wr(8'h01, 8'h02);
      s = n_start;
      c = n_cancel;
      trg(1'b1);
      rd_chk(8'h0C, 8'h01);
      trg(1'b0);
      rd_chk(8'h0C, 8'h00);
      chk(n_cancel, c + 1);
      wr(8'h0C, 8'h01);
      trg(1'b1);
      rd_chk(8'h0C, 8'h01);
      chk(n_start, s + 2);
      trg(1'b0);
   endtask : t_level
   task automatic t_test;
      logic [7:0] q;
      for (int i = 0; i < 2; i++) begin
         wr(8'h01, 8'h06 + 8'(i));
         wr(8'h0C, 8'h01);
         chk(test_run, 1'b1);
         test_fail <= (i == 0);
         test_done <= 1'b1;
         @(posedge clk);
         test_done <= 1'b0;
         rd_chk(8'h0C, 8'h00);
         dev_xfer(1'b0, 8'h00, 8'h00, q);
         chk(q[3], i == 0);
         dev_xfer(1'b0, 8'h00, 8'h00, q);
         chk(q[3], 1'b0);
      end
   endtask : t_test
   task automatic t_spc;
      int c;
      wr(8'h01, 8'h00);
      wr(8'h02, 8'h33);
      wr(8'h0C, 8'h01);
      c = n_cancel;
      wr(8'h01, 8'h80);
      chk(n_cancel, c + 1);
      repeat (hmt_pkg::SPC_CYCLES) @(posedge clk);
      rd_chk(8'h01, 8'h40);
      rd_chk(8'h02, 8'h00);
      rd_chk(8'h0C, 8'h00);
      chk(standby, 1'b1);
   endtask : t_spc
   task automatic t_irq;
      logic [31:0] v;
      logic [1:0]  r;
      chk(irq, 1'b0);
      axi_wr(8'h14, 32'h0000_0001);
      chk(irq, 1'b1);
      axi_rd(8'h0C, v, r);
      chk(v[0], 1'b1);
      axi_wr(8'h10, 32'h0000_0001);
      chk(irq, 1'b0);
      axi_wr(8'h14, 32'h0000_0000);
      wr(8'h02, 8'h11);
      chk(irq, 1'b0);
      // Command without its launch byte lane is dropped
      wstrb <= 4'h3;
      axi_wr(8'h00, {15'h0, 1'b1, 8'h02, 8'h22});
      chk(bresp, hmt_pkg::RESP_OKAY);
      wstrb <= 4'hF;
      rd_chk(8'h02, 8'h11);
      axi_rd(8'h20, v, r);
      chk(r, hmt_pkg::RESP_SLVERR);
   endtask : t_irq
   initial begin
      {rst, awvalid, wvalid, bready, arvalid, rready} <= 6'b10_0000;
      {seq_done, test_done, test_fail} <= 3'b000;
      {awaddr, araddr, wdata} <= 48'h0;
      wstrb <= 4'hF;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_realtime();
      t_modes();
      t_int();
      t_edge();
      t_level();
      t_test();
      t_spc();
      t_irq();
      end_sim();
   end
endmodule : haptic_mode_trigger_control_test

// ---- hmt_device.sv ----
// Operation
// - Bit 7 write runs soft power cycle, self-clears
// - Power cycle aborts playback, restores all defaults; a mode 1/2 trigger rise in its write cycle still sends play_start
// - Standby bit 6 resets high; zero means ready
// - Mode 0: fire bit write starts waveform
// - Mode 1: trigger rising edge sets fire bit
// - Mode 1: second rising edge cancels waveform
// - Mode 2: fire bit tracks trigger level
// - Mode 2: redundant trigger transition changes nothing
// - Mode 3: drive from pin, PWM/analog select
// - Mode 4: host sets coupling and select bits
// - Mode 5: drive from realtime value register
// - Mode 6: fire runs diagnostic, flag holds result
// - Mode 7: host loads parameters, fire runs calibration
// - Realtime value 8 bits, reset zero, mode 5
// - Realtime value signed unless format bit set
// - Host may rewrite realtime value any time; writes during the soft power cycle are ignored
// - Host idles via mode 0 or standby
// - Result flag bit 3, one fails, read clears
`timescale 1ns/100ps
module hmt_device (
   input  wire logic       clk,
   input  wire logic       rst,
   hmt_link_if.dev         link,
   input  wire logic       seq_done,
   input  wire logic       test_done,
   input  wire logic       test_fail,
   output logic            play_start,
   output logic            play_cancel,
   output logic            standby,
   output hmt_pkg::hmt_mode_t mode,
   output logic            drive_active,
   output logic            drive_from_pin,
   output logic            pin_is_analog,
   output logic            ac_coupling_enable,
   output logic [7:0]      realtime_drive_value,
   output logic            realtime_value_sign_format,
   output logic            test_run
);
   typedef struct packed {
      logic [hmt_pkg::SPC_W-1:0] spc_cnt;
      logic                      standby;
      hmt_pkg::hmt_mode_t        mode;
      logic [7:0]                rtv;
      logic                      go;
      logic                      fmt;
      logic                      acc;
      logic                      pwm_an;
      logic                      result;
      logic                      trig_d;
      logic                      ack;
      logic [7:0]                rdata;
      logic                      start;
      logic                      cancel;
   } hmt_dev_state_t;

   hmt_dev_state_t s_r;
   hmt_dev_state_t s_nxt;

   logic       wr;
   logic       rd;
   logic       rise;
   logic       fall;
   logic       ext_mode;
   logic [7:0] rd_val;

   assign wr       = link.req & link.we & ~s_r.ack;
   assign rd       = link.req & ~link.we & ~s_r.ack;
   assign rise     = link.trig & ~s_r.trig_d;
   assign fall     = ~link.trig & s_r.trig_d;
   assign ext_mode = (s_r.mode == hmt_pkg::HMT_EDGE) ||
                     (s_r.mode == hmt_pkg::HMT_LEVEL);

   always_comb begin
      rd_val = 8'h00;
      case (link.addr)
         hmt_pkg::DEV_STATUS_ADDR: begin
            rd_val[hmt_pkg::RESULT_BIT] = s_r.result;
         end
         hmt_pkg::DEV_MODE_ADDR: begin
            rd_val[hmt_pkg::SPC_BIT]     = (s_r.spc_cnt != '0);
            rd_val[hmt_pkg::STANDBY_BIT] = s_r.standby;
            rd_val[2:0]                  = s_r.mode;
         end
         hmt_pkg::DEV_RTV_ADDR: rd_val = s_r.rtv;
         hmt_pkg::DEV_GO_ADDR: begin
            rd_val[hmt_pkg::GO_BIT] = s_r.go;
         end
         hmt_pkg::DEV_CTRL_ADDR: begin
            rd_val[hmt_pkg::FMT_BIT]   = s_r.fmt;
            rd_val[hmt_pkg::ACC_BIT]   = s_r.acc;
            rd_val[hmt_pkg::PWMAN_BIT] = s_r.pwm_an;
         end
         default: rd_val = 8'h00;
      endcase
   end

   always_comb begin
      s_nxt        = s_r;
      s_nxt.ack    = link.req & ~s_r.ack;
      s_nxt.rdata  = rd ? rd_val : s_r.rdata;
      s_nxt.trig_d = link.trig;
      s_nxt.start  = 1'b0;
      s_nxt.cancel = 1'b0;
      if (s_r.spc_cnt != '0) begin
         // All registers held at default while the cycle runs
         s_nxt.standby = hmt_pkg::STANDBY_RST;
         s_nxt.mode    = hmt_pkg::HMT_INTERNAL;
         s_nxt.rtv     = hmt_pkg::RTV_RST;
         s_nxt.go      = 1'b0;
         s_nxt.fmt     = 1'b0;
         s_nxt.acc     = 1'b0;
         s_nxt.pwm_an  = 1'b0;
         s_nxt.result  = 1'b0;
         s_nxt.spc_cnt = s_r.spc_cnt - 1'b1;
      end else begin
         // Result flag: read clears, new outcome wins
         if (rd && link.addr == hmt_pkg::DEV_STATUS_ADDR) begin
            s_nxt.result = 1'b0;
         end
         if (wr) begin
            case (link.addr)
               hmt_pkg::DEV_MODE_ADDR: begin
                  s_nxt.standby = link.wdata[hmt_pkg::STANDBY_BIT];
                  s_nxt.mode    = hmt_pkg::hmt_mode_t'(link.wdata[2:0]);
                  if (link.wdata[hmt_pkg::SPC_BIT]) begin
                     s_nxt.spc_cnt = hmt_pkg::SPC_W'(hmt_pkg::SPC_CYCLES);
                     s_nxt.go      = 1'b0;
                     s_nxt.cancel  = s_r.go;
                     // Defaults at once, so the written mode never shows
                     s_nxt.standby = hmt_pkg::STANDBY_RST;
                     s_nxt.mode    = hmt_pkg::HMT_INTERNAL;
                     s_nxt.rtv     = hmt_pkg::RTV_RST;
                     s_nxt.fmt     = 1'b0;
                     s_nxt.acc     = 1'b0;
                     s_nxt.pwm_an  = 1'b0;
                     s_nxt.result  = 1'b0;
                  end
               end
               hmt_pkg::DEV_RTV_ADDR: s_nxt.rtv = link.wdata;
               hmt_pkg::DEV_GO_ADDR: begin
                  if (link.wdata[hmt_pkg::GO_BIT] && !s_r.go) begin
                     s_nxt.go    = 1'b1;
                     s_nxt.start = 1'b1;
                  end else if (!link.wdata[hmt_pkg::GO_BIT] && s_r.go) begin
                     s_nxt.go     = 1'b0;
                     s_nxt.cancel = 1'b1;
                  end
               end
               hmt_pkg::DEV_CTRL_ADDR: begin
                  s_nxt.fmt    = link.wdata[hmt_pkg::FMT_BIT];
                  s_nxt.acc    = link.wdata[hmt_pkg::ACC_BIT];
                  s_nxt.pwm_an = link.wdata[hmt_pkg::PWMAN_BIT];
               end
               default: ;
            endcase
         end
         // Sequence end frees the fire bit in internal and trigger modes (0, 1, 2)
         if (s_r.go && seq_done &&
             (ext_mode || s_r.mode == hmt_pkg::HMT_INTERNAL)) begin
            s_nxt.go = 1'b0;
         end
         // Diagnostic and calibration end
         if (s_r.go && test_done &&
             (s_r.mode == hmt_pkg::HMT_DIAG ||
              s_r.mode == hmt_pkg::HMT_CAL)) begin
            s_nxt.go     = 1'b0;
            s_nxt.result = test_fail;
         end
         // Pin edges checked last: a pin event beats a sequence end
         if (!s_r.standby) begin
            case (s_r.mode)
               hmt_pkg::HMT_EDGE: begin
                  if (rise && !s_r.go) begin
                     s_nxt.go    = 1'b1;
                     s_nxt.start = 1'b1;
                  end else if (rise) begin
                     s_nxt.go     = 1'b0;
                     s_nxt.cancel = 1'b1;
                  end
               end
               hmt_pkg::HMT_LEVEL: begin
                  // Redundant edges fall through untouched
                  if (rise && !s_r.go) begin
                     s_nxt.go    = 1'b1;
                     s_nxt.start = 1'b1;
                  end else if (fall && s_r.go) begin
                     s_nxt.go     = 1'b0;
                     s_nxt.cancel = 1'b1;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r         <= '0;
         s_r.standby <= hmt_pkg::STANDBY_RST;
         s_r.rtv     <= hmt_pkg::RTV_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign link.ack   = s_r.ack;
   assign link.rdata = s_r.rdata;

   assign play_start  = s_r.start;
   assign play_cancel = s_r.cancel;
   assign standby     = s_r.standby;
   assign mode        = s_r.mode;
   assign test_run    = s_r.go &&
                        (s_r.mode == hmt_pkg::HMT_DIAG ||
                         s_r.mode == hmt_pkg::HMT_CAL);
   // Continuous drive modes ignore the fire bit
   assign drive_active = !s_r.standby && (s_r.spc_cnt == '0) &&
                         (s_r.mode == hmt_pkg::HMT_PWM_ANALOG ||
                          s_r.mode == hmt_pkg::HMT_AUDIO ||
                          s_r.mode == hmt_pkg::HMT_REALTIME);
   assign drive_from_pin = s_r.mode == hmt_pkg::HMT_PWM_ANALOG ||
                           s_r.mode == hmt_pkg::HMT_AUDIO;
   assign pin_is_analog      = s_r.pwm_an;
   assign ac_coupling_enable = s_r.acc;
   // Value reaches the load only in realtime mode
   assign realtime_drive_value =
      (s_r.mode == hmt_pkg::HMT_REALTIME) ? s_r.rtv : 8'h00;
   assign realtime_value_sign_format = s_r.fmt;
endmodule : hmt_device

// ---- hmt_host.sv ----
`timescale 1ns/100ps
module hmt_host (
   input  wire logic        clk,
   input  wire logic        rst,
   hmt_link_if.host         link,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             irq
);
   typedef struct packed {
      logic       aw_h;
      logic [7:0] aw_a;
      logic       w_h;
      logic [31:0] w_d;
      logic       bvalid;
      logic [1:0] bresp;
      logic       rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic       req;
      logic       we;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] res;
      logic       trig;
      logic       ist;
      logic       ien;
   } hmt_host_state_t;

   hmt_host_state_t s_r;
   hmt_host_state_t s_nxt;
   logic            do_wr;
   logic            done;

   assign do_wr = s_r.aw_h && s_r.w_h && !s_r.bvalid;
   assign done  = s_r.req && link.ack;

   always_comb begin
      s_nxt = s_r;
      if (s_axi_awvalid && !s_r.aw_h) begin
         s_nxt.aw_h = 1'b1;
         s_nxt.aw_a = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_r.w_h) begin
         s_nxt.w_h = 1'b1;
         s_nxt.w_d = s_axi_wdata;
      end
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (done) begin
         s_nxt.req = 1'b0;
         s_nxt.res = link.rdata;
      end
      // Link completion sets the flag; set beats clear
      if (do_wr) begin
         s_nxt.aw_h   = 1'b0;
         s_nxt.w_h    = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp  = hmt_pkg::RESP_OKAY;
         case ({s_r.aw_a[7:2], 2'b00})
            hmt_pkg::H_CMD_ADDR: begin
               // A command while one is pending is dropped
               if (!s_r.req && s_axi_wstrb[2]) begin
                  s_nxt.req   = 1'b1;
                  s_nxt.we    = s_r.w_d[hmt_pkg::CMD_WR_BIT];
                  s_nxt.addr  = s_r.w_d[15:8];
                  s_nxt.wdata = s_r.w_d[7:0];
               end
            end
            hmt_pkg::H_TRIG_ADDR: begin
               if (s_axi_wstrb[0]) s_nxt.trig = s_r.w_d[0];
            end
            hmt_pkg::H_ICLR_ADDR: begin
               if (s_axi_wstrb[0] && s_r.w_d[0]) s_nxt.ist = 1'b0;
            end
            hmt_pkg::H_IEN_ADDR: begin
               if (s_axi_wstrb[0]) s_nxt.ien = s_r.w_d[0];
            end
            hmt_pkg::H_RES_ADDR, hmt_pkg::H_IST_ADDR: ;
            default: s_nxt.bresp = hmt_pkg::RESP_SLVERR;
         endcase
      end
      if (done) begin
         s_nxt.ist = 1'b1;
      end
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !s_r.rvalid) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp  = hmt_pkg::RESP_OKAY;
         s_nxt.rdata  = 32'h0000_0000;
         case ({s_axi_araddr[7:2], 2'b00})
            hmt_pkg::H_CMD_ADDR: begin
               s_nxt.rdata = {15'h0000, s_r.we, s_r.addr, s_r.wdata};
            end
            hmt_pkg::H_RES_ADDR: begin
               s_nxt.rdata = {23'h00_0000, s_r.req, s_r.res};
            end
            hmt_pkg::H_TRIG_ADDR: s_nxt.rdata = {31'h0000_0000, s_r.trig};
            hmt_pkg::H_IST_ADDR:  s_nxt.rdata = {31'h0000_0000, s_r.ist};
            hmt_pkg::H_IEN_ADDR:  s_nxt.rdata = {31'h0000_0000, s_r.ien};
            hmt_pkg::H_ICLR_ADDR: ;
            default: s_nxt.rresp = hmt_pkg::RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign s_axi_awready = !s_r.aw_h;
   assign s_axi_wready  = !s_r.w_h;
   assign s_axi_bvalid  = s_r.bvalid;
   assign s_axi_bresp   = s_r.bresp;
   assign s_axi_arready = !s_r.rvalid;
   assign s_axi_rvalid  = s_r.rvalid;
   assign s_axi_rresp   = s_r.rresp;
   assign s_axi_rdata   = s_r.rdata;
   assign link.req   = s_r.req;
   assign link.we    = s_r.we;
   assign link.addr  = s_r.addr;
   assign link.wdata = s_r.wdata;
   assign link.trig  = s_r.trig;
   assign irq = s_r.ist & s_r.ien;
endmodule : hmt_host

// ---- hmt_link_if.sv ----
`timescale 1ns/100ps
interface hmt_link_if;
   logic       req;
   logic       we;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       ack;
   logic       trig;

   modport dev  (input req, we, addr, wdata, trig, output rdata, ack);
   modport host (output req, we, addr, wdata, trig, input rdata, ack);
endinterface : hmt_link_if

// ---- hmt_pkg.sv ----
package hmt_pkg;
   // Clock and soft power-cycle timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int SPC_TIME_NS   = 500;
   localparam int SPC_CYCLES    =
      (SPC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SPC_W         = 4;

   // Device register offsets
   localparam logic [7:0] DEV_STATUS_ADDR = 8'h00;
   localparam logic [7:0] DEV_MODE_ADDR   = 8'h01;
   localparam logic [7:0] DEV_RTV_ADDR    = 8'h02;
   localparam logic [7:0] DEV_GO_ADDR     = 8'h0C;
   localparam logic [7:0] DEV_CTRL_ADDR   = 8'h1D;

   // Device field positions
   localparam int SPC_BIT     = 7;
   localparam int STANDBY_BIT = 6;
   localparam int RESULT_BIT  = 3;
   localparam int GO_BIT      = 0;
   localparam int FMT_BIT     = 3;
   localparam int ACC_BIT     = 1;
   localparam int PWMAN_BIT   = 0;

   // Device reset values
   localparam logic       STANDBY_RST = 1'b1;
   localparam logic [7:0] RTV_RST     = 8'h00;

   typedef enum logic [2:0] {
      HMT_INTERNAL, HMT_EDGE, HMT_LEVEL, HMT_PWM_ANALOG,
      HMT_AUDIO, HMT_REALTIME, HMT_DIAG, HMT_CAL
   } hmt_mode_t;

   // Host AXI4-Lite register offsets
   localparam logic [7:0] H_CMD_ADDR  = 8'h00;
   localparam logic [7:0] H_RES_ADDR  = 8'h04;
   localparam logic [7:0] H_TRIG_ADDR = 8'h08;
   localparam logic [7:0] H_IST_ADDR  = 8'h0C;
   localparam logic [7:0] H_ICLR_ADDR = 8'h10;
   localparam logic [7:0] H_IEN_ADDR  = 8'h14;
   localparam int CMD_WR_BIT  = 16;
   localparam int RES_BSY_BIT = 8;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : hmt_pkg

// ---- hmt_properties.sv ----
`timescale 1ns/100ps
module hmt_link_checker (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       req,
   input wire logic       we,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic       ack,
   input wire logic       trig
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic       take;
   logic       rd_ack;
   logic       mode_rd;
   logic       sb_r;
   logic [2:0] md_r;
   logic [7:0] rtv_r;
   logic [3:0] spc_r;
   assign take    = req && !ack;
   assign rd_ack  = ack && !we;
   assign mode_rd = rd_ack && addr == 8'h01;
   // Shadow of written values; soft cycle restores defaults
   always_ff @(posedge clk) begin
      spc_r <= (spc_r != 4'h0) ? spc_r - 4'h1 : 4'h0;
      if (rst) begin
         sb_r  <= 1'b1;
         md_r  <= 3'h0;
         rtv_r <= 8'h00;
         spc_r <= 4'h0;
      end else if (take && we && addr == 8'h01 && wdata[7]) begin
         sb_r  <= 1'b1;
         md_r  <= 3'h0;
         rtv_r <= 8'h00;
         // Margin over the five busy cycles
         spc_r <= 4'h8;
      end else if (take && we && addr == 8'h01) begin
         sb_r <= wdata[6];
         md_r <= wdata[2:0];
      end else if (take && we && addr == 8'h02) begin
         rtv_r <= wdata;
      end
   end
   AST_ACK_AFTER_TAKE: assert property (ack |-> $past(take))
      else $error("ack without a pending request");
   AST_ACK_ONE_CYCLE: assert property (take |=> ack ##1 !ack)
      else $error("ack not a one-cycle answer");
   AST_REQ_HELD: assert property (take |=> req && $stable({we, addr, wdata}))
      else $error("request changed before ack");
   AST_REQ_DROP: assert property (ack |=> !req)
      else $error("request not dropped after ack");
   AST_STANDBY_RD: assert property (mode_rd |-> rdata[6] == sb_r)
      else $error("standby bit readback wrong");
   AST_MODE_RD: assert property (mode_rd |-> rdata[2:0] == md_r)
      else $error("mode field readback wrong");
   AST_SPC_CLEARS: assert property (mode_rd && rdata[7] |-> spc_r != 4'h0)
      else $error("soft cycle bit did not clear");
   AST_RTV_RD: assert property (rd_ack && addr == 8'h02 |-> rdata == rtv_r)
      else $error("realtime value readback wrong");
endmodule : hmt_link_checker
